// File: hw/vic_pkg.sv
// Functional notes
// - all enabled source requests merge into one request to the core
// - two priority levels exist: high and low
// - pick by priority level first, then lowest vector number
// - one flag per source; source sets it, software write clears it
// - per-source enable gates each flag into the combined request
// - per-source priority bit selects high or low level
// - global control holds global enables; status register reports state
// - status bits show high, low or main-line execution context
// - 21-bit table base held in three software registers
// - while locked, writes to the base registers are blocked
// - config bit 3 selects multi-vector, bit 4 selects lock-once
// - with lock-once, lock flag toggles once per reset only
// - table holds 68 vectors, one per source
// - each entry is one 16-bit word, two byte addresses
// - multi-vector bit decides whether the table is used
// - legacy mode vectors to high or low fixed location
// - multi-vector handler address is table entry shifted left two
// - fixed response latency regardless of source
// - two context levels; high may preempt a low handler
// - legacy high vector is base, low is base plus eight words
// - entry address is base plus twice vector, captured in 21 bits
// - base resets to 00 0008h
// - unlock needs 55h then aah on consecutive lock writes
package vic_pkg;
    localparam int NUM_SRC = 68;
    localparam int VEC_W = 7;
    localparam int ADDR_W = 21;
    localparam int REG_W = 8;
    localparam int RA_W = 8;
    localparam int NUM_REGS8 = 9; // 68 sources fill 9 byte registers
    // register offsets
    localparam logic [RA_W-1:0] OFS_GCTRL = 8'h00;
    localparam logic [RA_W-1:0] OFS_STATUS = 8'h01;
    localparam logic [RA_W-1:0] OFS_BASE_L = 8'h02;
    localparam logic [RA_W-1:0] OFS_BASE_H = 8'h03;
    localparam logic [RA_W-1:0] OFS_BASE_U = 8'h04;
    localparam logic [RA_W-1:0] OFS_LOCK = 8'h05;
    localparam logic [RA_W-1:0] OFS_VAD_L = 8'h06;
    localparam logic [RA_W-1:0] OFS_VAD_H = 8'h07;
    localparam logic [RA_W-1:0] OFS_VAD_U = 8'h08;
    localparam logic [RA_W-1:0] OFS_FLAG = 8'h10;
    localparam logic [RA_W-1:0] OFS_EN = 8'h20;
    localparam logic [RA_W-1:0] OFS_PRI = 8'h30;
    // field positions
    localparam int GC_HIGH_EN = 7;
    localparam int GC_LOW_EN = 6;
    localparam int GC_PRI_EN = 5;
    localparam int ST_HIGH_ACT = 7;
    localparam int ST_LOW_ACT = 6;
    localparam int LOCK_BIT = 0;
    localparam int CFG_MVEC = 3;
    localparam int CFG_ONCE = 4;
    // values
    localparam logic [ADDR_W-1:0] BASE_RST = 21'h00_0008;
    localparam logic [REG_W-1:0] KEY_A = 8'h55;
    localparam logic [REG_W-1:0] KEY_B = 8'haa;
    localparam logic [ADDR_W-1:0] LOW_VEC_OFS = 21'h00_0010; // 8 words
    localparam int ISR_SHIFT = 2;
    localparam int LATENCY = 3; // cycles from request to vector presented
    typedef enum logic [1:0] {CTX_MAIN, CTX_LOW, CTX_HIGH} ctx_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_A, KEY_OPEN} key_t;
endpackage : vic_pkg

// File: hw/vector_interrupt_ctrl.sv
module vector_interrupt_ctrl
    import vic_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [RA_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_W-1:0] reg_rdata,
    input wire logic [N-1:0] src_event,
    input wire logic [REG_W-1:0] config_word_low,
    output logic core_irq,
    output logic core_irq_high,
    output logic [ADDR_W-1:0] fetch_addr,
    output logic fetch_is_table,
    input wire logic core_ack,
    input wire logic [15:0] table_entry,
    input wire logic table_valid,
    output logic [ADDR_W-1:0] isr_addr,
    output logic isr_valid,
    input wire logic core_return
);
    // ************************************************
    // registers
    // ************************************************
    logic [N-1:0] flag_q, en_q, pri_q;
    logic [REG_W-1:0] gctrl_q;
    logic [ADDR_W-1:0] base_q, vad_q;
    logic locked_q, lock_used_q;
    key_t key_q;
    ctx_t ctx_q, saved_q;
    logic [VEC_W-1:0] sel_vec;
    logic sel_hit, sel_high;
    logic [1:0] lat_q;
    logic pend_q;
    logic pend_high_q;
    logic [N-1:0] clr_mask;
    logic mvec, once, hi_req;
    assign mvec = config_word_low[CFG_MVEC];
    assign once = config_word_low[CFG_ONCE];

    // write clear mask for the flag bytes
    always_comb begin
        clr_mask = '0;
        for (int i = 0; i < N; i++) begin
            if (reg_wr && reg_addr == OFS_FLAG + RA_W'(i / REG_W)
                && !reg_wdata[i % REG_W]) begin
                clr_mask[i] = 1'b1;
            end
        end
    end

    // set wins over clear so no event is lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~clr_mask) | src_event;
        end
    end

    // enable and priority byte registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_q <= '0;
            pri_q <= '0;
        end else if (reg_wr) begin
            for (int i = 0; i < N; i++) begin
                if (reg_addr == OFS_EN + RA_W'(i / REG_W)) begin
                    en_q[i] <= reg_wdata[i % REG_W];
                end
                if (reg_addr == OFS_PRI + RA_W'(i / REG_W)) begin
                    pri_q[i] <= reg_wdata[i % REG_W];
                end
            end
        end
    end

    // global control
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gctrl_q <= '0;
        end else if (reg_wr && reg_addr == OFS_GCTRL) begin
            gctrl_q <= reg_wdata;
        end
    end

    // ************************************************
    // lock key sequence
    // ************************************************
    // key window opens only for the write right after 55h then aah
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            key_q <= KEY_IDLE;
        end else if (reg_wr && reg_addr == OFS_LOCK) begin
            case (key_q)
                KEY_IDLE: key_q <= (reg_wdata == KEY_A) ? KEY_GOT_A : KEY_IDLE;
                KEY_GOT_A: key_q <= (reg_wdata == KEY_B) ? KEY_OPEN :
                    ((reg_wdata == KEY_A) ? KEY_GOT_A : KEY_IDLE);
                // a fresh 55h restarts the key from any state
                default: key_q <= (reg_wdata == KEY_A) ? KEY_GOT_A : KEY_IDLE;
            endcase
        end else if (reg_wr) begin
            key_q <= KEY_IDLE; // any other write breaks the sequence
        end
    end

    // lock flag, with single-toggle option
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            locked_q <= 1'b0;
            lock_used_q <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_LOCK && key_q == KEY_OPEN
                     && !gctrl_q[GC_HIGH_EN]) begin
            if (!(once && lock_used_q && !reg_wdata[LOCK_BIT])) begin
                locked_q <= reg_wdata[LOCK_BIT];
            end
            if (reg_wdata[LOCK_BIT]) begin
                lock_used_q <= 1'b1;
            end
        end
    end

    // base registers, three bytes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            base_q <= BASE_RST;
        end else if (reg_wr && !locked_q) begin
            if (reg_addr == OFS_BASE_L) begin
                base_q[7:0] <= reg_wdata;
            end else if (reg_addr == OFS_BASE_H) begin
                base_q[15:8] <= reg_wdata;
            end else if (reg_addr == OFS_BASE_U) begin
                base_q[ADDR_W-1:16] <= reg_wdata[ADDR_W-17:0];
            end
        end
    end

    // ************************************************
    // arbitration
    // ************************************************
    // high level first, lowest vector within a level
    always_comb begin
        logic hit_h, hit_l;
        logic [VEC_W-1:0] vh, vl;
        logic act;
        act = 1'b0;
        hit_h = 1'b0;
        hit_l = 1'b0;
        vh = '0;
        vl = '0;
        for (int i = N - 1; i >= 0; i--) begin
            act = flag_q[i] & en_q[i];
            if (act && (pri_q[i] || !gctrl_q[GC_PRI_EN])) begin
                hit_h = 1'b1;
                vh = VEC_W'(i);
            end else if (act) begin
                hit_l = 1'b1;
                vl = VEC_W'(i);
            end
        end
        hi_req = hit_h && gctrl_q[GC_HIGH_EN] && ctx_q != CTX_HIGH;
        // low held off while high pending or high handler active
        sel_high = hi_req;
        sel_hit = hi_req || (hit_l && !hit_h && gctrl_q[GC_HIGH_EN]
            && gctrl_q[GC_LOW_EN] && ctx_q == CTX_MAIN);
        sel_vec = hi_req ? vh : vl;
    end

    // request pipeline: fixed latency from flag to core_irq
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lat_q <= '0;
            pend_q <= 1'b0;
            pend_high_q <= 1'b0;
            vad_q <= '0;
            fetch_addr <= '0;
        end else if (pend_q) begin
            if (core_ack) begin
                pend_q <= 1'b0;
                lat_q <= '0;
            end
        end else if (sel_hit) begin
            // counting keeps latency the same for every source
            if (lat_q == 2'(LATENCY - 1)) begin
                pend_q <= 1'b1;
                pend_high_q <= sel_high;
                if (mvec) begin
                    vad_q <= base_q + ADDR_W'({sel_vec, 1'b0});
                    fetch_addr <= base_q + ADDR_W'({sel_vec, 1'b0});
                end else begin
                    fetch_addr <= sel_high ? base_q
                        : base_q + LOW_VEC_OFS;
                end
            end else begin
                lat_q <= lat_q + 2'd1;
            end
        end else begin
            lat_q <= '0;
        end
    end
    assign core_irq = pend_q;
    assign core_irq_high = pend_high_q;
    assign fetch_is_table = mvec;

    // handler address from table entry
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            isr_addr <= '0;
            isr_valid <= 1'b0;
        end else begin
            isr_valid <= mvec && table_valid;
            if (mvec && table_valid) begin
                isr_addr <= ADDR_W'({table_entry, 2'b00});
            end
        end
    end

    // ************************************************
    // execution context, one saved level
    // ************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctx_q <= CTX_MAIN;
            saved_q <= CTX_MAIN;
        end else if (pend_q && core_ack) begin
            saved_q <= ctx_q;
            ctx_q <= pend_high_q ? CTX_HIGH : CTX_LOW;
        end else if (core_return) begin
            ctx_q <= (ctx_q == CTX_HIGH) ? saved_q : CTX_MAIN;
            saved_q <= CTX_MAIN;
        end
    end

    // ************************************************
    // read port
    // ************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            if (reg_addr == OFS_GCTRL) begin
                reg_rdata <= gctrl_q;
            end else if (reg_addr == OFS_STATUS) begin
                reg_rdata[ST_HIGH_ACT] <= (ctx_q == CTX_HIGH);
                reg_rdata[ST_LOW_ACT] <= (ctx_q == CTX_LOW)
                    || (saved_q == CTX_LOW);
            end else if (reg_addr == OFS_BASE_L) begin
                reg_rdata <= base_q[7:0];
            end else if (reg_addr == OFS_BASE_H) begin
                reg_rdata <= base_q[15:8];
            end else if (reg_addr == OFS_BASE_U) begin
                reg_rdata <= REG_W'(base_q[ADDR_W-1:16]);
            end else if (reg_addr == OFS_LOCK) begin
                reg_rdata[LOCK_BIT] <= locked_q;
            end else if (reg_addr == OFS_VAD_L) begin
                reg_rdata <= vad_q[7:0];
            end else if (reg_addr == OFS_VAD_H) begin
                reg_rdata <= vad_q[15:8];
            end else if (reg_addr == OFS_VAD_U) begin
                reg_rdata <= REG_W'(vad_q[ADDR_W-1:16]);
            end else begin
                for (int i = 0; i < N; i++) begin
                    if (reg_addr == OFS_FLAG + RA_W'(i / REG_W)) begin
                        reg_rdata[i % REG_W] <= flag_q[i];
                    end else if (reg_addr == OFS_EN + RA_W'(i / REG_W)) begin
                        reg_rdata[i % REG_W] <= en_q[i];
                    end else if (reg_addr == OFS_PRI + RA_W'(i / REG_W)) begin
                        reg_rdata[i % REG_W] <= pri_q[i];
                    end
                end
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_key;
        reg_wr && reg_addr == OFS_LOCK && reg_wdata == KEY_A
        ##1 reg_wr && reg_addr == OFS_LOCK && reg_wdata == KEY_B;
    endsequence
    chk_base_locked: assert property (@(posedge clock) disable iff (sys_rst)
        locked_q && reg_wr |=> $stable(base_q))
        else $error("base changed while locked");
    chk_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        src_event != '0
        |=> (flag_q & $past(src_event)) == $past(src_event))
        else $error("flag not set by event");
    chk_lock_key: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(locked_q) |-> $past(key_q) == KEY_OPEN)
        else $error("lock changed without key");
    chk_key_open: assert property (@(posedge clock) disable iff (sys_rst)
        s_key |=> key_q == KEY_OPEN)
        else $error("key sequence not accepted");
    chk_once_lock: assert property (@(posedge clock) disable iff (sys_rst)
        once && lock_used_q && locked_q |=> locked_q)
        else $error("relocked flag cleared");
    chk_irq_latency: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(pend_q) |-> $past(sel_hit, 3) && $past(sel_hit, 1))
        else $error("latency not fixed");
    chk_vec_addr: assert property (@(posedge clock) disable iff (sys_rst)
        $past(mvec) && $rose(pend_q) |-> fetch_addr == vad_q
            && fetch_addr - $past(base_q)
            == ADDR_W'(2 * $past(sel_vec)))
        else $error("vector address mismatch");
    chk_isr_shift: assert property (@(posedge clock) disable iff (sys_rst)
        mvec && table_valid |=> isr_addr[1:0] == 2'b00 && isr_valid)
        else $error("isr address not shifted");
    chk_low_held: assert property (@(posedge clock) disable iff (sys_rst)
        ctx_q == CTX_HIGH |-> !sel_hit)
        else $error("request taken inside high handler");
    // core handshake: the request stands until taken, then drops
    sequence s_take;
        pend_q && core_ack;
    endsequence
    chk_irq_hold: assert property (@(posedge clock) disable iff (sys_rst)
        pend_q && !core_ack |=> pend_q && $stable(fetch_addr))
        else $error("request dropped before ack");
    chk_ack_drop: assert property (@(posedge clock) disable iff (sys_rst)
        s_take |=> !pend_q)
        else $error("request kept after ack");
    // context follows the level of the request taken
    chk_ctx_high: assert property (@(posedge clock) disable iff (sys_rst)
        s_take ##0 pend_high_q |=> ctx_q == CTX_HIGH)
        else $error("high context not entered");
    chk_ctx_low: assert property (@(posedge clock) disable iff (sys_rst)
        s_take ##0 !pend_high_q |=> ctx_q == CTX_LOW)
        else $error("low context not entered");
    // legacy mode: fixed high entry at the base, low entry above it
    chk_legacy_vec: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(pend_q) && !$past(mvec) |-> fetch_addr == $past(base_q)
            + (pend_high_q ? ADDR_W'(0) : LOW_VEC_OFS))
        else $error("legacy vector address wrong");
    // reset leaves the controller unlocked and quiet
    chk_reset_state: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> base_q == BASE_RST && !locked_q
            && flag_q == '0 && en_q == '0 && pri_q == '0)
        else $error("state not cleared by reset");
endmodule : vector_interrupt_ctrl

// File: testbench/core_model.sv
module core_model
    import vic_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic core_irq,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic fetch_is_table,
    output logic core_ack = 1'b0,
    output logic [15:0] table_entry = 16'h0000,
    output logic table_valid = 1'b0,
    output logic core_return = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // **********
    // core side: take request, fetch entry, run handler
    // **********
    logic [15:0] word;
    // slow mode holds the ack back, so the request has to stand meanwhile
    always begin
        @(posedge clock);
        #1;
        if (!sys_rst && core_irq === 1'b1) begin
            word = fetch_addr[15:0] ^ 16'h5a3c;
            repeat (slow ? 5 : 0) @(posedge clock);
            core_ack <= 1'b1;
            @(posedge clock);
            core_ack <= 1'b0;
            if (fetch_is_table) begin
                table_entry <= word;
                table_valid <= 1'b1;
                @(posedge clock);
                table_valid <= 1'b0;
                table_entry <= ~word; // stale word must not look valid
            end
            repeat (40) @(posedge clock);
            core_return <= 1'b1;
            @(posedge clock);
            core_return <= 1'b0;
        end
    end
endmodule : core_model

// File: testbench/vectored_interrupt_controller_tb.sv
module vectored_interrupt_controller_tb
    import vic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // **********
    // harness
    // **********
    logic clock = 1'b0, sys_rst = 1'b1, slow = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [RA_W-1:0] reg_addr = '0;
    logic [REG_W-1:0] reg_wdata = '0, cfg = 8'h08, reg_rdata, rv;
    logic [NUM_SRC-1:0] src_event = '0;
    logic core_irq, core_irq_high, fetch_is_table, core_ack;
    logic table_valid, isr_valid, core_return;
    logic [ADDR_W-1:0] fetch_addr, isr_addr, base = BASE_RST;
    logic [15:0] table_entry;
    logic [REG_W-1:0] en_b [NUM_REGS8];
    logic [REG_W-1:0] pr_b [NUM_REGS8];
    logic [31:0] rng = 32'd55;
    int n_errors = 0, num_checks = 0, lat, a, b;
    // free-running system clock
    always #5 clock = ~clock;
    vector_interrupt_ctrl DUT (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_event(src_event),
        .config_word_low(cfg), .core_irq(core_irq),
        .core_irq_high(core_irq_high), .fetch_addr(fetch_addr),
        .fetch_is_table(fetch_is_table), .core_ack(core_ack),
        .table_entry(table_entry), .table_valid(table_valid),
        .isr_addr(isr_addr), .isr_valid(isr_valid),
        .core_return(core_return));
    core_model core (
        .clock(clock), .sys_rst(sys_rst), .slow(slow),
        .core_irq(core_irq), .fetch_addr(fetch_addr),
        .fetch_is_table(fetch_is_table), .core_ack(core_ack),
        .table_entry(table_entry), .table_valid(table_valid),
        .core_return(core_return));
    // **********
    // helpers
    // **********
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic [ADDR_W-1:0] fetch_of(input int v,
            input logic hi, input logic mv);
        if (mv)
            return base + ADDR_W'(2 * v);
        return hi ? base : base + LOW_VEC_OFS;
    endfunction : fetch_of
    task automatic chk(input string w, input logic [31:0] e,
            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // strobe is left high so back-to-back writes need no gap
    task automatic wr(input logic [RA_W-1:0] ad, input logic [REG_W-1:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
    endtask : wr
    task automatic idle();
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : idle
    task automatic rd(input logic [RA_W-1:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rv = reg_rdata;
        @(posedge clock);
    endtask : rd
    task automatic rdc(input string w, input logic [31:0] e,
            input logic [RA_W-1:0] ad);
        rd(ad);
        chk(w, e, 32'(rv));
    endtask : rdc
    task automatic key(input logic [REG_W-1:0] d);
        wr(OFS_LOCK, KEY_A);
        wr(OFS_LOCK, KEY_B);
        wr(OFS_LOCK, d);
        idle();
    endtask : key
    task automatic clr();
        for (int i = 0; i < NUM_REGS8; i++) begin
            en_b[i] = '0;
            pr_b[i] = '0;
        end
    endtask : clr
    // global control first, so no stale flag fires mid-update
    task automatic prog(input logic [REG_W-1:0] gc);
        wr(OFS_GCTRL, gc);
        for (int i = 0; i < NUM_REGS8; i++) begin
            wr(OFS_EN + RA_W'(i), en_b[i]);
            wr(OFS_PRI + RA_W'(i), pr_b[i]);
        end
        idle();
    endtask : prog
    task automatic fire(input logic [NUM_SRC-1:0] m);
        src_event <= m;
        @(posedge clock);
        src_event <= '0;
        for (lat = 0; lat < 60 && core_irq !== 1'b1; lat++)
            @(negedge clock);
    endtask : fire
    task automatic serve(input int v, input logic hi, input logic mv);
        logic [ADDR_W-1:0] fa, ia;
        fa = fetch_of(v, hi, mv);
        for (int n = 0; n < 300 && core_irq !== 1'b1; n++)
            @(negedge clock);
        chk("fetch_addr", 32'(fa), 32'(fetch_addr));
        chk("irq_high", 32'(hi), 32'(core_irq_high));
        chk("fetch_is_table", 32'(mv), 32'(fetch_is_table));
        if (mv) begin
            for (int n = 0; n < 50 && isr_valid !== 1'b1; n++)
                @(negedge clock);
            ia = ADDR_W'(fa[15:0] ^ 16'h5a3c) << ISR_SHIFT;
            chk("isr_addr", 32'(ia), 32'(isr_addr));
        end
        // a slow core takes the request late; status only moves on ack
        for (int n = 0; n < 50 && core_irq !== 1'b0; n++)
            @(negedge clock);
        @(posedge clock);
        rd(OFS_STATUS);
        chk("status", {24'h0, hi, !hi, 6'h0}, 32'(rv & 8'hc0));
        if (mv) begin
            rdc("vad_l", 32'(fa[7:0]), OFS_VAD_L);
            rdc("vad_h", 32'(fa[15:8]), OFS_VAD_H);
            rdc("vad_u", 32'(fa[20:16]), OFS_VAD_U);
        end
        wr(OFS_FLAG + RA_W'(v / 8), ~(8'h01 << (v % 8)));
        idle();
    endtask : serve
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rdc("base_l", 32'(BASE_RST[7:0]), OFS_BASE_L);
        rdc("base_h", 32'(BASE_RST[15:8]), OFS_BASE_H);
        rdc("base_u", 32'(BASE_RST[20:16]), OFS_BASE_U);
        rdc("lock", 0, OFS_LOCK);
        rdc("unmapped", 0, 8'h0f);
        rdc("gctrl", 0, OFS_GCTRL);
        for (int i = 0; i < NUM_REGS8; i++) begin
            rdc("flag", 0, OFS_FLAG + RA_W'(i));
            rdc("enable", 0, OFS_EN + RA_W'(i));
            rdc("priority", 0, OFS_PRI + RA_W'(i));
        end
    endtask : do_reset
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // **********
    // scenarios
    // **********
    initial begin
        clr();
        do_reset();
        $display("test reset done");
        rng = xs(rng);
        base = {2'b00, rng[18:1], 1'b0};
        wr(OFS_BASE_L, base[7:0]);
        wr(OFS_BASE_H, base[15:8]);
        wr(OFS_BASE_U, 8'(base[20:16]));
        idle();
        rdc("base", 32'(base[7:0]), OFS_BASE_L);
        rdc("base", 32'(base[20:16]), OFS_BASE_U);
        // single random sources, random level and core speed
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            a = int'(rng % NUM_SRC);
            slow <= rng[8];
            clr();
            en_b[a / 8][a % 8] = 1'b1;
            pr_b[a / 8][a % 8] = rng[9];
            prog(8'he0);
            fire(NUM_SRC'(1) << a);
            chk("latency", LATENCY + 1, lat);
            serve(a, rng[9], 1'b1);
            repeat (60) @(posedge clock);
        end
        // concurrent pairs: same level, then low against high
        for (int m = 0; m < 4; m++) begin
            rng = xs(rng);
            a = int'(rng % 34);
            b = a + 1 + int'(rng[15:8] % 33);
            cfg <= m[1] ? 8'h08 : 8'h00;
            clr();
            en_b[a / 8][a % 8] = 1'b1;
            en_b[b / 8][b % 8] = 1'b1;
            pr_b[b / 8][b % 8] = 1'b1;
            pr_b[a / 8][a % 8] = !m[0];
            prog(8'he0);
            fire((NUM_SRC'(1) << a) | (NUM_SRC'(1) << b));
            serve(m[0] ? b : a, 1'b1, m[1]);
            serve(m[0] ? a : b, !m[0], m[1]);
            repeat (60) @(posedge clock);
        end
        $display("test vectoring done");
        cfg <= 8'h08;
        clr();
        prog(8'he0);
        fire(NUM_SRC'(1) << a);
        chk("masked irq", 60, lat);
        @(posedge clock);
        rd(OFS_FLAG + RA_W'(a / 8));
        chk("flag", 1, 32'((rv >> (a % 8)) & 8'h01));
        en_b[a / 8][a % 8] = 1'b1;
        prog(8'h00);
        fire(NUM_SRC'(1) << a);
        chk("global off irq", 60, lat);
        @(posedge clock);
        $display("test gating done");
        cfg <= 8'h18;
        wr(OFS_LOCK, 8'h01);
        idle();
        rdc("lock no key", 0, OFS_LOCK);
        key(8'h01);
        rdc("lock set", 1, OFS_LOCK);
        wr(OFS_BASE_L, ~base[7:0]);
        idle();
        rdc("locked base", 32'(base[7:0]), OFS_BASE_L);
        key(8'h00);
        rdc("lock once", 1, OFS_LOCK);
        do_reset();
        $display("test lock done");
        conclude();
    end
    // the scenarios need a few thousand cycles at most
    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        conclude();
    end
endmodule : vectored_interrupt_controller_tb
